// ===== phis_top.sv
// Purpose : Holdover history averaging and input clock selection for the
//           second PLL channel, with its Avalon-MM register file.
// Assumes : Alarm and frequency inputs are synchronous to i_clk.
// Notes   : Every bus access answers in two cycles.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps

module phis_top #(
  parameter int unsigned FREQ_W   = 16,
  parameter int unsigned TICK_CYC = phis_pkg::HIST_TICK_CYC
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire phis_pkg::phis_avs_req_s  i_avs,
  output phis_pkg::phis_avs_rsp_s       o_avs,
  input  wire logic [3:0]               i_loss_of_signal_alarm,
  input  wire logic [3:0]               i_out_of_frequency_alarm,
  input  wire logic [FREQ_W-1:0]        i_freq_sample,
  input  wire logic                     i_fast_acquire,
  output logic [1:0]                    o_active_input,
  output phis_pkg::phis_pll_state_e     o_pll_state,
  output logic [FREQ_W-1:0]             o_holdover_freq,
  output logic                          o_history_valid,
  output logic                          o_phase_buildout,
  output logic [9:0]                    o_phase_threshold
);
  import phis_pkg::*;

  localparam int unsigned SUM_W = FREQ_W + 32;
  localparam int unsigned TCW   = $clog2(TICK_CYC);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  if (FREQ_W < 8 || FREQ_W > 32) begin : g_bad_freq_w
    $error("FREQ_W must be 8 to 32");
  end
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // --------------------------------------------------------------------
  // Register file and bus slave
  // --------------------------------------------------------------------
  logic [15:0]     regs [NREG];
  logic [15:0]     next_regs [NREG];
  phis_avs_rsp_s   next_avs;
  logic [31:0]     rd_word;
  logic            fast_q;
  logic            bus_req;
  logic            bus_hit;
  logic            wr_take;
  logic [IDX_W-1:0] bus_idx;

  assign bus_req = i_avs.read | i_avs.write;
  assign bus_idx = i_avs.address[IDX_W+1:2];
  assign bus_hit = (i_avs.address[ADDR_W-1:IDX_W+2] == '0);
  // Write lands only at the edge where waitrequest is seen low
  assign wr_take = i_avs.write & ~o_avs.waitrequest;

  // Read mux; unmapped words and reserved bits read as zero
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < NREG; i++) begin
      if (bus_hit && bus_idx == REG_IDX[i]) begin
        rd_word[15:0] = regs[i] & REG_MASK[i];
      end
    end
    if (bus_hit && bus_idx == IDX_STATUS) begin
      rd_word[HIST_VAL_BIT] = o_history_valid;
      rd_word[FAST_BIT]     = fast_q;
    end
  end

  // Byte lanes 0 and 1 write the masked bits of a register
  always_comb begin
    next_regs = regs;
    for (int i = 0; i < NREG; i++) begin
      if (wr_take && bus_hit && bus_idx == REG_IDX[i]) begin
        if (i_avs.byteenable[0]) begin
          next_regs[i][7:0] = i_avs.writedata[7:0] & REG_MASK[i][7:0];
        end
        if (i_avs.byteenable[1]) begin
          next_regs[i][15:8] = i_avs.writedata[15:8] & REG_MASK[i][15:8];
        end
      end
    end
  end

  // One wait cycle, then a single ready cycle per access
  always_comb begin
    next_avs             = o_avs;
    next_avs.waitrequest = ~(bus_req & o_avs.waitrequest);
    if (i_avs.read && o_avs.waitrequest) begin
      next_avs.readdata = rd_word;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= REG_RST[i];
      end
      o_avs  <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
      fast_q <= 1'b0;
    end else begin
      regs   <= next_regs;
      o_avs  <= next_avs;
      fast_q <= i_fast_acquire;
    end
  end

  // --------------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------------
  logic [2:0] man_choice;
  logic [1:0] sel_mode;
  logic [4:0] len_field;
  logic [4:0] dly_field;
  logic [3:0] los_msk;
  logic [3:0] oof_msk;
  logic       hold_en;
  logic       force_hold;

  assign man_choice = regs[SLOT_MANUAL][MAN_SEL_LSB +: 3];
  assign hold_en    = regs[SLOT_HOLD][HOLD_EN_BIT];
  assign len_field  = regs[SLOT_LEN][4:0];
  assign dly_field  = regs[SLOT_DLY][4:0];
  assign force_hold = regs[SLOT_FORCE][FORCE_BIT];
  assign sel_mode   = regs[SLOT_SWITCH][MODE_LSB +: 2];
  assign los_msk    = regs[SLOT_MASK][LOS_MSK_LSB +: 4];
  assign oof_msk    = regs[SLOT_MASK][OOF_MSK_LSB +: 4];
  // Style bit and threshold go straight out of their registers
  assign o_phase_buildout  = regs[SLOT_SWITCH][STYLE_BIT];
  assign o_phase_threshold = {regs[SLOT_THR_HI][1:0],
                              regs[SLOT_THR_LO][7:0]};

  // --------------------------------------------------------------------
  // Per-input qualification
  // --------------------------------------------------------------------
  logic [3:0] alarm;
  logic [3:0] qual;
  logic [2:0] rank [4];

  for (genvar n = 0; n < 4; n++) begin : g_input
    localparam int unsigned RLSB = (n % 2 == 0) ? RANK_LO_LSB : RANK_HI_LSB;
    assign rank[n]  = (n < 2) ? regs[SLOT_RANK01][RLSB +: 3]
                              : regs[SLOT_RANK23][RLSB +: 3];
    assign alarm[n] = (i_loss_of_signal_alarm[n] & ~los_msk[n])
                    | (i_out_of_frequency_alarm[n] & ~oof_msk[n]);
    // Reserved ranks 5..7 leave the input unusable
    assign qual[n]  = (rank[n] != 3'h0) && (rank[n] <= RANK_MAX) &&
                      !alarm[n];
  end

  // --------------------------------------------------------------------
  // Input choice and PLL state
  // --------------------------------------------------------------------
  phis_pll_state_e next_state;
  logic [1:0]      next_active;
  logic [1:0]      best;
  logic [1:0]      cand;
  logic [2:0]      best_rank;
  logic            best_found;
  logic            have_input;
  logic            restart;

  // Lowest rank value wins; ties go to the lower input number
  always_comb begin
    best       = 2'h0;
    best_rank  = 3'h7;
    best_found = 1'b0;
    for (int n = 0; n < 4; n++) begin
      if (qual[n] && (!best_found || rank[n] < best_rank)) begin
        best       = 2'(n);
        best_rank  = rank[n];
        best_found = 1'b1;
      end
    end
  end

  always_comb begin
    cand       = o_active_input;
    have_input = 1'b0;
    unique case (sel_mode)
      SEL_AUTO_NREV: begin
        // Stay on a still-clean input to avoid needless hits
        if (qual[o_active_input] && o_pll_state == PHIS_NORMAL) begin
          cand       = o_active_input;
          have_input = 1'b1;
        end else begin
          cand       = best;
          have_input = best_found;
        end
      end
      SEL_AUTO_REV: begin
        cand       = best;
        have_input = best_found;
      end
      default: begin
        // Manual, and reserved code 3 treated as manual
        cand       = man_choice[1:0];
        have_input = !man_choice[2] && !alarm[man_choice[1:0]];
      end
    endcase
  end

  always_comb begin
    next_active = have_input ? cand : o_active_input;
    if (!have_input || force_hold) begin
      // Holdover only with enable and usable history, else free-run
      next_state = (hold_en && o_history_valid) ? PHIS_HOLDOVER
                                                : PHIS_FREERUN;
    end else begin
      next_state = PHIS_NORMAL;
    end
    // A newly presented or newly chosen input starts history afresh
    restart = (next_state == PHIS_NORMAL) &&
              (o_pll_state != PHIS_NORMAL ||
               next_active != o_active_input);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pll_state    <= PHIS_FREERUN;
      o_active_input <= 2'h0;
    end else begin
      o_pll_state    <= next_state;
      o_active_input <= next_active;
    end
  end

  // --------------------------------------------------------------------
  // History unit tick
  // --------------------------------------------------------------------
  logic [TCW-1:0] tick_cnt;
  logic [TCW-1:0] next_tick_cnt;
  logic           tick;

  assign tick          = (tick_cnt == TCW'(TICK_CYC - 1));
  assign next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // --------------------------------------------------------------------
  // Frequency history
  // --------------------------------------------------------------------
  logic [SUM_W-1:0]  sum;
  logic [SUM_W-1:0]  next_sum;
  logic [SUM_W-1:0]  sum_total;
  logic [31:0]       blk_left;
  logic [31:0]       next_blk_left;
  logic [4:0]        blk_shift;
  logic [4:0]        next_blk_shift;
  logic [31:0]       dly_left;
  logic [31:0]       next_dly_left;
  logic [FREQ_W-1:0] pend_avg;
  logic [FREQ_W-1:0] next_pend_avg;
  logic [FREQ_W-1:0] next_hold_freq;
  logic              pend_busy;
  logic              next_pend_busy;
  logic              next_hist_valid;
  logic              acc_en;
  logic              blk_done;

  // Accumulate only while locked now and next cycle
  assign acc_en = (o_pll_state == PHIS_NORMAL) &&
                  (next_state == PHIS_NORMAL);

  // A window of 2^len samples spans 2^len units, so the mean is a
  // shift. A block that ends while an older one waits out its delay is
  // dropped: one delay stage instead of a deep history memory.
  always_comb begin
    next_sum        = sum;
    next_blk_left   = blk_left;
    next_blk_shift  = blk_shift;
    next_dly_left   = dly_left;
    next_pend_avg   = pend_avg;
    next_pend_busy  = pend_busy;
    next_hold_freq  = o_holdover_freq;
    next_hist_valid = o_history_valid;
    sum_total       = sum + SUM_W'(i_freq_sample);
    blk_done        = 1'b0;
    if (restart) begin
      next_sum        = '0;
      next_blk_left   = 32'h1 << len_field;
      next_blk_shift  = len_field;
      next_pend_busy  = 1'b0;
      next_hold_freq  = '0;
      next_hist_valid = 1'b0;
    end else if (acc_en && tick) begin
      if (blk_left == 32'h1) begin
        blk_done       = 1'b1;
        next_sum       = '0;
        next_blk_left  = 32'h1 << len_field;
        next_blk_shift = len_field;
      end else begin
        next_sum      = sum_total;
        next_blk_left = blk_left - 32'h1;
      end
      if (pend_busy) begin
        if (dly_left == 32'h1) begin
          next_hold_freq  = pend_avg;
          next_hist_valid = 1'b1;
          next_pend_busy  = 1'b0;
        end else begin
          next_dly_left = dly_left - 32'h1;
        end
      end else if (blk_done) begin
        next_pend_avg  = FREQ_W'(sum_total >> blk_shift);
        next_dly_left  = 32'h1 << dly_field;
        next_pend_busy = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum             <= '0;
      blk_left        <= 32'h1;
      blk_shift       <= 5'h00;
      dly_left        <= 32'h1;
      pend_avg        <= '0;
      pend_busy       <= 1'b0;
      o_holdover_freq <= '0;
      o_history_valid <= 1'b0;
    end else begin
      sum             <= next_sum;
      blk_left        <= next_blk_left;
      blk_shift       <= next_blk_shift;
      dly_left        <= next_dly_left;
      pend_avg        <= next_pend_avg;
      pend_busy       <= next_pend_busy;
      o_holdover_freq <= next_hold_freq;
      o_history_valid <= next_hist_valid;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_force_hold;
    (force_hold && hold_en && o_history_valid) |=>
      o_pll_state == PHIS_HOLDOVER;
  endproperty
  a_force_hold: assert property (p_force_hold)
    else $error("forced holdover not entered");

  property p_hold_disabled;
    !hold_en |=> o_pll_state != PHIS_HOLDOVER;
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("holdover while disabled");

  property p_los_used;
    (sel_mode == SEL_MANUAL && !man_choice[2] &&
     i_loss_of_signal_alarm[man_choice[1:0]] &&
     !los_msk[man_choice[1:0]]) |=> o_pll_state != PHIS_NORMAL;
  endproperty
  a_los_used: assert property (p_los_used)
    else $error("unmasked loss alarm ignored");

  property p_oof_used;
    (sel_mode == SEL_MANUAL && !man_choice[2] &&
     i_out_of_frequency_alarm[man_choice[1:0]] &&
     !oof_msk[man_choice[1:0]]) |=> o_pll_state != PHIS_NORMAL;
  endproperty
  a_oof_used: assert property (p_oof_used)
    else $error("unmasked frequency alarm ignored");

  property p_manual_pick;
    (sel_mode == SEL_MANUAL && !man_choice[2] && !force_hold &&
     los_msk == 4'hf && oof_msk == 4'hf) |=>
      o_active_input == $past(man_choice[1:0]) &&
      o_pll_state == PHIS_NORMAL;
  endproperty
  a_manual_pick: assert property (p_manual_pick)
    else $error("manual choice not followed");

  property p_revert;
    (sel_mode == SEL_AUTO_REV && best_found) |=>
      o_active_input == $past(best);
  endproperty
  a_revert: assert property (p_revert)
    else $error("revertive mode not on best input");

  // Reserved mode 3 runs as manual, so only the two automatic codes count
  property p_no_candidate;
    ((sel_mode == SEL_AUTO_NREV || sel_mode == SEL_AUTO_REV) &&
     qual == 4'h0) |=> o_pll_state != PHIS_NORMAL;
  endproperty
  a_no_candidate: assert property (p_no_candidate)
    else $error("locked with no qualified input");

  property p_frozen;
    (o_pll_state != PHIS_NORMAL && next_state != PHIS_NORMAL) |=>
      $stable(o_holdover_freq) && $stable(sum) && $stable(o_history_valid);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("history moved outside lock");

  property p_restart_clears;
    (o_pll_state != PHIS_NORMAL && next_state == PHIS_NORMAL) |=>
      !o_history_valid ##1 !o_history_valid;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("history not cleared on new input");

  property p_fast_read;
    (i_avs.read && o_avs.waitrequest && bus_hit &&
     bus_idx == IDX_STATUS) |=> o_avs.readdata[FAST_BIT] == $past(fast_q);
  endproperty
  a_fast_read: assert property (p_fast_read)
    else $error("fast acquire status misread");

  property p_bus_answer;
    (bus_req && o_avs.waitrequest) |=> !o_avs.waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus access not answered");

  c_holdover: cover property (o_pll_state == PHIS_HOLDOVER);
  c_freerun_from_lock: cover property (
    o_pll_state == PHIS_NORMAL ##1 o_pll_state == PHIS_FREERUN);
  c_history_valid: cover property ($rose(o_history_valid));
  c_revert_switch: cover property (
    sel_mode == SEL_AUTO_REV ##1 $changed(o_active_input));

endmodule

// ===== phis_pkg.sv
// Purpose : Shared constants, register map and carriers for the holdover
//           and input selection block of the second PLL channel.
// Assumes : 32-bit Avalon-MM slave, byte addressed, one register per word.
// Notes   : Register byte address is four times the register index.
package phis_pkg;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned HIST_TICK_PS  = 268000;
  // History unit rounded down to whole cycles
  localparam int unsigned HIST_TICK_CYC = HIST_TICK_PS / CLK_PERIOD_PS;

  // --------------------------------------------------------------------
  // Bus geometry
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned IDX_W  = 11;
  localparam int unsigned NREG   = 26;

  // --------------------------------------------------------------------
  // Register indices
  // --------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_MANUAL_SEL  = 11'h52a;
  localparam logic [IDX_W-1:0] IDX_HOLD_CTRL   = 11'h52c;
  localparam logic [IDX_W-1:0] IDX_STATUS      = 11'h53f;

  // Slots of the register store that the logic reads
  localparam int unsigned SLOT_MANUAL = 0;
  localparam int unsigned SLOT_HOLD   = 1;
  localparam int unsigned SLOT_LEN    = 3;
  localparam int unsigned SLOT_DLY    = 4;
  localparam int unsigned SLOT_FORCE  = 9;
  localparam int unsigned SLOT_SWITCH = 10;
  localparam int unsigned SLOT_MASK   = 11;
  localparam int unsigned SLOT_RANK01 = 12;
  localparam int unsigned SLOT_RANK23 = 13;
  localparam int unsigned SLOT_THR_LO = 15;
  localparam int unsigned SLOT_THR_HI = 16;

  // Index, writable mask and reset value of each stored register
  localparam logic [IDX_W-1:0] REG_IDX [NREG] = '{
    IDX_MANUAL_SEL, IDX_HOLD_CTRL, 11'h52d, 11'h52e, 11'h52f, 11'h531,
    11'h532, 11'h533, 11'h534, 11'h535, 11'h536, 11'h537, 11'h538,
    11'h539, 11'h53a, 11'h53b, 11'h53c, 11'h53d, 11'h53e, 11'h542,
    11'h543, 11'h544, 11'h545, 11'h588, 11'h589, 11'h59b};
  localparam logic [15:0] REG_MASK [NREG] = '{
    16'h000e, 16'h0001, 16'h0002, 16'h001f, 16'h001f, 16'h001f,
    16'h00ff, 16'h00ff, 16'h00ff, 16'h0001, 16'h0007, 16'h00ff, 16'h0077,
    16'h0077, 16'h000f, 16'h00ff, 16'h0003, 16'h001f, 16'h001f, 16'h00ff,
    16'h00ff, 16'h0003, 16'h0002, 16'h000f, 16'h1fff, 16'h00f6};
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // --------------------------------------------------------------------
  // Field positions and codes
  // --------------------------------------------------------------------
  localparam int unsigned HOLD_EN_BIT   = 0;
  localparam int unsigned MAN_SEL_LSB   = 1;
  localparam int unsigned FORCE_BIT     = 0;
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned STYLE_BIT     = 2;
  localparam int unsigned LOS_MSK_LSB   = 0;
  localparam int unsigned OOF_MSK_LSB   = 4;
  localparam int unsigned RANK_LO_LSB   = 0;
  localparam int unsigned RANK_HI_LSB   = 4;
  localparam int unsigned HIST_VAL_BIT  = 1;
  localparam int unsigned FAST_BIT      = 2;
  localparam logic [2:0]  RANK_MAX      = 3'h4;
  localparam logic [1:0]  SEL_MANUAL    = 2'h0;
  localparam logic [1:0]  SEL_AUTO_NREV = 2'h1;
  localparam logic [1:0]  SEL_AUTO_REV  = 2'h2;

  typedef enum logic [1:0] {
    PHIS_NORMAL,
    PHIS_HOLDOVER,
    PHIS_FREERUN
  } phis_pll_state_e;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } phis_avs_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } phis_avs_rsp_s;

endpackage

// ===== tb.sv
// Purpose : Self-checking bench for holdover and input selection.
// Assumes : One clock, Avalon-MM register access with waitrequest.
// Notes   : A short history tick keeps holdover runs brief.
`timescale 1ns/1ps
module tb;
  import phis_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } phis_row_s;
  logic            i_clk;
  logic            i_rst_n;
  phis_avs_req_s   avs;
  phis_avs_rsp_s   rsp;
  logic [3:0]      loss_of_signal_alarm;
  logic [3:0]      out_of_frequency_alarm;
  logic [15:0]     freq;
  logic            fast;
  logic [1:0]      act;
  phis_pll_state_e st;
  logic [15:0]     hfreq;
  logic            hval;
  logic            pbo;
  logic [9:0]      thr;
  int              error_cnt;
  int              comparisons;
  phis_row_s       rows [11];

  phis_top #(.FREQ_W(16), .TICK_CYC(2)) phis_top_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(avs), .o_avs(rsp),
    .i_loss_of_signal_alarm(loss_of_signal_alarm), .i_out_of_frequency_alarm(out_of_frequency_alarm),
    .i_freq_sample(freq), .i_fast_acquire(fast), .o_active_input(act),
    .o_pll_state(st), .o_holdover_freq(hfreq), .o_history_valid(hval),
    .o_phase_buildout(pbo), .o_phase_threshold(thr));

  // Free-running 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task complete_run();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Request held until waitrequest is seen low; bounded wait
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    avs <= '{read: !w, write: w, address: a, writedata: d,
             byteenable: 4'h3};
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    q = rsp.readdata;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    if (n >= 20) begin
      chk(1, 0);
      complete_run();
    end
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Wait for committed history, bounded
  task wait_valid();
    int n;
    for (n = 0; n < 200 && hval !== 1'b1; n++) @(posedge i_clk);
    // A history that never commits is a hang: count it and stop
    if (hval !== 1'b1) begin
      chk(1, 0);
      complete_run();
    end
  endtask

  // Apply alarms and check the chosen input
  task sel(input logic [3:0] l, input logic [3:0] o, input logic [1:0] e);
    loss_of_signal_alarm <= l;
    out_of_frequency_alarm <= o;
    repeat (3) @(posedge i_clk);
    chk(act, e);
    chk(st, PHIS_NORMAL);
  endtask

  initial begin
    // Write value, expected readback: masks and reserved places
    rows = '{
      '{16'h14b8, 8'hff, 8'h1f},
      '{16'h14bc, 8'hff, 8'h1f},
      '{16'h14dc, 8'hff, 8'hff},
      '{16'h14e0, 8'hff, 8'h77},
      '{16'h14e4, 8'hff, 8'h77},
      '{16'h14ec, 8'ha5, 8'ha5},
      '{16'h14f0, 8'hff, 8'h03},
      '{16'h14d8, 8'hff, 8'h07},
      '{16'h14fc, 8'hff, 8'h00},
      '{16'h1000, 8'hff, 8'h00},
      '{16'h14e8, 8'h02, 8'h02}};
    i_rst_n = 1'b0;
    avs = '0;
    // All loss alarms up: no lock, so no history before the status reads
    loss_of_signal_alarm = 4'hf;
    out_of_frequency_alarm = 4'h0;
    freq = 16'h1234;
    fast = 1'b0;
    repeat (2) @(posedge i_clk);
    chk(rsp.waitrequest, 1);
    chk(st, PHIS_FREERUN);
    i_rst_n <= 1'b1;
    rd(16'h14e8, 32'h2);
    rd(16'h14b0, 32'h0);
    fast <= 1'b1;
    rd(16'h14fc, 32'h4);
    fast <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, {24'h0, rows[i].d});
      rd(rows[i].a, {24'h0, rows[i].e});
    end
    chk(thr, 10'h3a5);
    chk(pbo, 1);
    $display("register test done");
    loss_of_signal_alarm <= 4'h0;
    // Manual input 2, holdover enabled, short history
    wr(16'h14dc, 32'h0);
    wr(16'h14d8, 32'h0);
    wr(16'h14b8, 32'h0);
    wr(16'h14bc, 32'h0);
    wr(16'h14a8, 32'h4);
    wr(16'h14b0, 32'h1);
    wait_valid();
    chk(hval, 1);
    chk(hfreq, 16'h1234);
    chk(act, 2);
    chk(pbo, 0);
    rd(16'h14fc, 32'h2);
    loss_of_signal_alarm <= 4'h4;
    freq <= 16'h0777;
    repeat (4) @(posedge i_clk);
    chk(st, PHIS_HOLDOVER);
    chk(hfreq, 16'h1234);
    wr(16'h14dc, 32'h4);
    repeat (2) @(posedge i_clk);
    chk(st, PHIS_NORMAL);
    chk(hval, 0);
    wait_valid();
    chk(hfreq, 16'h0777);
    wr(16'h14d4, 32'h1);
    repeat (2) @(posedge i_clk);
    chk(st, PHIS_HOLDOVER);
    wr(16'h14b0, 32'h0);
    repeat (2) @(posedge i_clk);
    chk(st, PHIS_FREERUN);
    wr(16'h14d4, 32'h0);
    wr(16'h14b0, 32'h1);
    $display("holdover test done");
    // Ranks: in0=2 in1=1 in2=none in3=3, revertive then not
    loss_of_signal_alarm <= 4'h0;
    wr(16'h14dc, 32'h0);
    wr(16'h14e0, 32'h12);
    wr(16'h14e4, 32'h30);
    wr(16'h14d8, 32'h2);
    sel(4'h0, 4'h0, 2'd1);
    sel(4'h0, 4'h2, 2'd0);
    sel(4'h0, 4'h0, 2'd1);
    sel(4'h1, 4'h2, 2'd3);
    wr(16'h14d8, 32'h1);
    sel(4'h8, 4'h0, 2'd1);
    sel(4'h0, 4'h2, 2'd0);
    sel(4'h0, 4'h0, 2'd0);
    $display("selection test done");
    complete_run();
  end
endmodule
